// ==== src/sfc_core.sv ====
// Purpose: flag, bit-transfer and MCU control ops, data access timing
// Assumes: ops arrive from logic on i_clk; APB master on the same clock
// Notes: pready drops only while a port op and a CMD write collide
//
// Function
// - Half-carry set, one cycle, others kept
// - Half-carry clear, one cycle, others kept
// - Signed-test set, one cycle, only S
// - Sleep: one cycle, flags kept, sleep request
// - Watchdog restart: one cycle, restart pulse out
// - Break: one cycle, flags kept, debug notified
// - Listed access counts hold for SRAM only
// - NONVOLATILE_MEMORY_CONTROLLER access takes at least one extra
// - Stall further while arbitration is busy
// - Read/write bits return last stored value
// - Read-only bits ignore writes, stay readable
// - Write-only bits read as don't care
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module sfc_core #(
	parameter int NUM_REGS = 4
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_instr_valid,
	input wire sfc_pkg::sfc_instr_type i_instr,
	input wire logic i_dacc_valid,
	input wire logic i_dacc_nvm,
	input wire logic i_arb_busy,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic o_instr_done,
	output logic [7:0] o_flags,
	output logic o_sleep_req,
	output logic o_wdt_restart,
	output logic o_break_req,
	output logic o_dacc_ready,
	output logic o_dacc_done,
	output logic o_stall
);
	logic rst_meta_q;
	logic rst_sync_q;
	logic rstn;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] gpr_q [NUM_REGS];
	logic [7:0] op_cnt_q;
	logic sleep_q;
	logic sleep_req_q;
	logic wdt_q;
	logic brk_q;
	logic done_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic acc;
	logic wr;
	logic cmd_wr;
	logic cmd_hold;
	logic exec;
	sfc_pkg::sfc_instr_type ins;
	logic [7:0] cur_reg;
	sfc_pkg::sfc_dacc_state_type da_q;
	logic [3:0] da_cnt_q;
	logic da_nvm_q;
	logic da_block;

	// Reset release through two flops
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rstn = rst_sync_q;

	function automatic logic is_reg(input logic [sfc_pkg::ADDR_W-1:0] a,
			input logic [sfc_pkg::ADDR_W-1:0] off);
		is_reg = (a == off);
	endfunction : is_reg

	function automatic logic is_gpr(input logic [sfc_pkg::ADDR_W-1:0] a);
		is_gpr = (a >= sfc_pkg::OFF_GPR_BASE) && (a[1:0] == 2'b00) &&
			(a < sfc_pkg::OFF_GPR_BASE + sfc_pkg::ADDR_W'(4 * NUM_REGS));
	endfunction : is_gpr

	function automatic logic mapped(input logic [sfc_pkg::ADDR_W-1:0] a);
		mapped = is_reg(a, sfc_pkg::OFF_FLAGS) ||
			is_reg(a, sfc_pkg::OFF_STATUS) ||
			is_reg(a, sfc_pkg::OFF_CMD) || is_gpr(a);
	endfunction : mapped

	// APB access phase; a CMD write waits while the port issues an op
	assign acc = psel && penable;
	assign cmd_hold = acc && pwrite && is_reg(paddr, sfc_pkg::OFF_CMD) &&
		i_instr_valid;
	assign pready = !cmd_hold;
	assign wr = acc && pwrite && pready && mapped(paddr);
	assign cmd_wr = wr && is_reg(paddr, sfc_pkg::OFF_CMD);
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// Instruction source: port first, then a command write
	always_comb begin
		exec = i_instr_valid || cmd_wr;
		ins = i_instr;
		if (!i_instr_valid) begin
			ins.op = sfc_pkg::sfc_op_type'(pwdata[sfc_pkg::CMD_OP_LSB +: 4]);
			ins.bit_idx = pwdata[sfc_pkg::CMD_BIT_LSB +: 3];
			ins.reg_idx = pwdata[sfc_pkg::CMD_REG_LSB +: 2];
		end
	end
	assign cur_reg = gpr_q[ins.reg_idx];

	// Processor flag register update
	always_comb begin
		flags_d = flags_q;
		if (wr && is_reg(paddr, sfc_pkg::OFF_FLAGS)) begin
			flags_d = pwdata[7:0];
		end
		if (exec) begin
			unique case (ins.op)
			sfc_pkg::OP_TSTORE: flags_d[sfc_pkg::FLAG_T] = cur_reg[ins.bit_idx];
			sfc_pkg::OP_FSET: flags_d[ins.bit_idx] = 1'b1;
			sfc_pkg::OP_FCLR: flags_d[ins.bit_idx] = 1'b0;
			sfc_pkg::OP_HSET: flags_d[sfc_pkg::FLAG_H] = 1'b1;
			sfc_pkg::OP_HCLR: flags_d[sfc_pkg::FLAG_H] = 1'b0;
			sfc_pkg::OP_SSET: flags_d[sfc_pkg::FLAG_S] = 1'b1;
			default: flags_d = flags_d;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= sfc_pkg::FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end
	assign o_flags = flags_q;

	// General registers: APB write, then bit load from T
	generate
		for (genvar g = 0; g < NUM_REGS; g++) begin : g_gpr
			always_ff @(posedge i_clk or negedge rstn) begin
				if (!rstn) begin
					gpr_q[g] <= sfc_pkg::GPR_RESET;
				end else if (exec && ins.op == sfc_pkg::OP_TLOAD &&
						ins.reg_idx == 2'(g)) begin
					gpr_q[g] <= (wr && paddr == sfc_pkg::OFF_GPR_BASE +
						sfc_pkg::ADDR_W'(4 * g)) ? pwdata[7:0] : gpr_q[g];
					gpr_q[g][ins.bit_idx] <= flags_q[sfc_pkg::FLAG_T];
				end else if (wr && paddr == sfc_pkg::OFF_GPR_BASE +
						sfc_pkg::ADDR_W'(4 * g)) begin
					gpr_q[g] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// Control op pulses, one cycle each, flags untouched
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_req_q <= 1'b0;
			wdt_q <= 1'b0;
			brk_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			sleep_req_q <= exec && ins.op == sfc_pkg::OP_SLEEP;
			wdt_q <= exec && ins.op == sfc_pkg::OP_WDOG;
			brk_q <= exec && ins.op == sfc_pkg::OP_BREAK;
			done_q <= exec;
		end
	end
	assign o_sleep_req = sleep_req_q;
	assign o_wdt_restart = wdt_q;
	assign o_break_req = brk_q;
	assign o_instr_done = done_q;

	// Status: last executed op was sleep, executed op count
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_q <= 1'b0;
			op_cnt_q <= 8'h00;
		end else if (exec) begin
			sleep_q <= ins.op == sfc_pkg::OP_SLEEP;
			op_cnt_q <= op_cnt_q + 8'h01;
		end
	end

	// Data access timing
	assign da_block = i_arb_busy;
	assign o_dacc_ready = da_q == sfc_pkg::DA_IDLE;
	assign o_dacc_done = da_q == sfc_pkg::DA_WAIT && da_cnt_q == 4'h0 &&
		!da_block;
	assign o_stall = da_q == sfc_pkg::DA_WAIT && !o_dacc_done;

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			da_q <= sfc_pkg::DA_IDLE;
			da_cnt_q <= 4'h0;
			da_nvm_q <= 1'b0;
		end else begin
			unique case (da_q)
			sfc_pkg::DA_IDLE: begin
				if (i_dacc_valid) begin
					da_q <= sfc_pkg::DA_WAIT;
					da_nvm_q <= i_dacc_nvm;
					da_cnt_q <= i_dacc_nvm ?
						sfc_pkg::DACC_SRAM_EXTRA + sfc_pkg::DACC_NVM_EXTRA
						: sfc_pkg::DACC_SRAM_EXTRA;
				end
			end
			sfc_pkg::DA_WAIT: begin
				if (da_cnt_q != 4'h0) begin
					da_cnt_q <= da_cnt_q - 4'h1;
				end else if (!da_block) begin
					da_q <= sfc_pkg::DA_IDLE;
				end
			end
			endcase
		end
	end

	// Read data captured in setup; CMD is write-only and reads zero
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= !mapped(paddr);
			prdata_q <= 32'h0000_0000;
			if (!pwrite) begin
				if (is_reg(paddr, sfc_pkg::OFF_FLAGS)) begin
					prdata_q[7:0] <= flags_q;
				end else if (is_reg(paddr, sfc_pkg::OFF_STATUS)) begin
					prdata_q[sfc_pkg::STAT_STALL] <= o_stall;
					prdata_q[sfc_pkg::STAT_SLEEP] <= sleep_q;
					prdata_q[sfc_pkg::STAT_CNT_LSB +: 8] <= op_cnt_q;
				end else if (is_gpr(paddr)) begin
					prdata_q[7:0] <= gpr_q[paddr[3:2]];
				end
			end
		end
	end

	// Checks
	logic fl_wr;
	assign fl_wr = wr && is_reg(paddr, sfc_pkg::OFF_FLAGS);

	sequence s_exec(sfc_pkg::sfc_op_type o);
		exec && ins.op == o && !fl_wr;
	endsequence

	sequence s_nvm_start;
		da_q == sfc_pkg::DA_IDLE && i_dacc_valid && i_dacc_nvm;
	endsequence

	a_half_set: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_HSET) |=> o_flags ==
			($past(o_flags) | (8'h01 << sfc_pkg::FLAG_H)))
		else $error("half-carry set wrong");

	a_half_clear: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_HCLR) |=> o_flags ==
			($past(o_flags) & ~(8'h01 << sfc_pkg::FLAG_H)))
		else $error("half-carry clear wrong");

	a_sign_set: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_SSET) |=> o_flags ==
			($past(o_flags) | (8'h01 << sfc_pkg::FLAG_S)))
		else $error("signed-test set wrong");

	a_sleep_req_pulse: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_SLEEP) |=> o_sleep_req && $stable(o_flags))
		else $error("sleep op not signalled");

	a_wdt_restart_pulse: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_WDOG) |=> o_wdt_restart && $stable(o_flags))
		else $error("watchdog restart not signalled");

	a_break_notify: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_BREAK) |=> o_break_req && $stable(o_flags))
		else $error("break op not signalled");

	// Back-to-back breaks legally keep the request high
	a_break_single: assert property (@(posedge i_clk) disable iff (!rstn)
		(o_break_req && !(exec && ins.op == sfc_pkg::OP_BREAK)) |=>
			!o_break_req)
		else $error("break not a single pulse");

	a_sram_latency: assert property (@(posedge i_clk) disable iff (!rstn)
		(o_dacc_ready && i_dacc_valid && !i_dacc_nvm) ##1 !i_arb_busy
			|-> o_dacc_done)
		else $error("sram access not one cycle");

	a_nvm_extra_cycle: assert property (@(posedge i_clk) disable iff (!rstn)
		s_nvm_start |=> !o_dacc_done ##1 (o_dacc_done || i_arb_busy))
		else $error("nvm access timing wrong");

	a_busy_stalls: assert property (@(posedge i_clk) disable iff (!rstn)
		(da_q == sfc_pkg::DA_WAIT && i_arb_busy) |-> o_stall && !o_dacc_done)
		else $error("access completed while busy");

	a_flags_rw: assert property (@(posedge i_clk) disable iff (!rstn)
		(fl_wr && !exec) |=> o_flags == $past(pwdata[7:0]))
		else $error("flag write not stored");

	a_store_copies: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_TSTORE) |=>
			o_flags[sfc_pkg::FLAG_T] == $past(cur_reg[ins.bit_idx]))
		else $error("bit store wrong");

	a_load_copies: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_TLOAD) |=>
			gpr_q[$past(ins.reg_idx)][$past(ins.bit_idx)] ==
			$past(o_flags[sfc_pkg::FLAG_T]))
		else $error("bit load wrong");

	a_fset_indexed: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_FSET) |=> o_flags[$past(ins.bit_idx)])
		else $error("indexed flag set wrong");

	a_fclr_indexed: assert property (@(posedge i_clk) disable iff (!rstn)
		s_exec(sfc_pkg::OP_FCLR) |=> !o_flags[$past(ins.bit_idx)])
		else $error("indexed flag clear wrong");

	a_status_ro: assert property (@(posedge i_clk) disable iff (!rstn)
		(wr && paddr == sfc_pkg::OFF_STATUS && !exec) |=>
			$stable(op_cnt_q) && $stable(sleep_q))
		else $error("status changed by a write");

	a_cmd_rd_zero: assert property (@(posedge i_clk) disable iff (!rstn)
		(acc && !pwrite && paddr == sfc_pkg::OFF_CMD) |->
			prdata == 32'h0000_0000)
		else $error("command read not zero");
endmodule : sfc_core

// ==== src/sfc_pkg.sv ====
// Purpose: shared constants and types for the flag and control op unit
// Assumes: 32-bit APB register bus, one clock
// Notes: flag positions follow the processor flag register layout
package sfc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_GPR_BASE = 8'h10;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] GPR_RESET = 8'h00;
	// Flag positions in the processor flag register
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// Cycles beyond the first for a plain SRAM access, and NONVOLATILE_MEMORY_CONTROLLER extra
	localparam logic [3:0] DACC_SRAM_EXTRA = 4'h0;
	localparam logic [3:0] DACC_NVM_EXTRA = 4'h1;
	// Command and status register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BIT_LSB = 4;
	localparam int CMD_REG_LSB = 8;
	localparam int STAT_STALL = 0;
	localparam int STAT_SLEEP = 1;
	localparam int STAT_CNT_LSB = 8;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_TSTORE,
		OP_TLOAD,
		OP_FSET,
		OP_FCLR,
		OP_HSET,
		OP_HCLR,
		OP_SSET,
		OP_SLEEP,
		OP_WDOG,
		OP_BREAK
	} sfc_op_type;

	typedef struct packed {
		sfc_op_type op;
		logic [2:0] bit_idx;
		logic [1:0] reg_idx;
	} sfc_instr_type;

	typedef enum logic {DA_IDLE, DA_WAIT} sfc_dacc_state_type;
endpackage : sfc_pkg

// ==== bench/sfc_src_model.sv ====
// Purpose: op stream and data bus model facing the op unit
// Assumes: called from tasks, changes right after rising edges
// Notes: released target line shows the inverse of its last value
`timescale 1ns/1ns
module sfc_src_model (
	input wire logic i_clk,
	input wire logic i_dacc_done,
	output logic o_instr_valid,
	output sfc_pkg::sfc_instr_type o_instr,
	output logic o_dacc_valid,
	output logic o_dacc_nvm,
	output logic o_arb_busy
);
	initial begin
		o_instr_valid = 1'b0;
		o_instr = '0;
		o_dacc_valid = 1'b0;
		o_dacc_nvm = 1'b0;
		o_arb_busy = 1'b0;
	end
	task op(input sfc_pkg::sfc_op_type c, input logic [2:0] b,
		input logic [1:0] r);
		@(posedge i_clk);
		o_instr_valid <= 1'b1;
		o_instr <= '{op: c, bit_idx: b, reg_idx: r};
		@(posedge i_clk);
		o_instr_valid <= 1'b0;
		o_instr <= ~o_instr;
	endtask : op
	// Busy held nb cycles after the access is taken
	task dacc(input logic nonvolatile_memory_controller, input int nb, output int lat);
		@(posedge i_clk);
		o_dacc_valid <= 1'b1;
		o_dacc_nvm <= nonvolatile_memory_controller;
		@(posedge i_clk);
		o_dacc_valid <= 1'b0;
		o_dacc_nvm <= ~nonvolatile_memory_controller;
		o_arb_busy <= (nb > 0);
		lat = 1;
		forever begin
			#1;
			if (i_dacc_done === 1'b1 || lat > 20) break;
			@(posedge i_clk);
			lat++;
			if (lat > nb) o_arb_busy <= 1'b0;
		end
	endtask : dacc
endmodule : sfc_src_model

// ==== bench/status_flag_and_mcu_control_ops_tb.sv ====
// Purpose: self-checking bench for the flag and control op unit
// Assumes: APB master and op source change just after rising edges
// Notes: one task per scenario
`timescale 1ns/1ns
module status_flag_and_mcu_control_ops_tb;
	logic i_clk, i_rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, flags;
	logic [31:0] pwdata, prdata, rv;
	logic done, slp, wdt, brk, dready, ddone, stall, iv, dv, dn, busy, ev;
	sfc_pkg::sfc_instr_type instr;
	int fail_count = 0;
	int check_count = 0;
	int lat;
	int stall_cyc = 0;
	// Cycles in which the access stall was shown
	always @(posedge i_clk) begin
		if (stall === 1'b1) begin
			stall_cyc <= stall_cyc + 1;
		end
	end
	sfc_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_instr_valid(iv),
		.i_instr(instr), .i_dacc_valid(dv), .i_dacc_nvm(dn),
		.i_arb_busy(busy), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .o_instr_done(done),
		.o_flags(flags), .o_sleep_req(slp), .o_wdt_restart(wdt),
		.o_break_req(brk), .o_dacc_ready(dready), .o_dacc_done(ddone),
		.o_stall(stall));
	sfc_src_model u_src (.i_clk(i_clk), .i_dacc_done(ddone),
		.o_instr_valid(iv), .o_instr(instr), .o_dacc_valid(dv),
		.o_dacc_nvm(dn), .o_arb_busy(busy));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task op_chk(input sfc_pkg::sfc_op_type c, input logic [2:0] b,
		input logic [1:0] r, input logic [7:0] e);
		u_src.op(c, b, r);
		#1;
		chk("done", 32'h0000_0001, 32'(done));
		chk("flags", 32'(e), 32'(flags));
	endtask : op_chk
	task t_half;
		apb(1'b1, sfc_pkg::OFF_FLAGS, 32'h0000_008a);
		op_chk(sfc_pkg::OP_HSET, 3'h0, 2'h0, 8'haa);
		op_chk(sfc_pkg::OP_HCLR, 3'h0, 2'h0, 8'h8a);
		op_chk(sfc_pkg::OP_SSET, 3'h0, 2'h0, 8'h9a);
	endtask : t_half
	task t_index;
		logic [7:0] e;
		e = 8'h9a;
		for (int i = 0; i < 16; i++) begin
			e[i % 8] = (i < 8);
			if (i < 8) op_chk(sfc_pkg::OP_FSET, 3'(i), 2'h0, e);
			else op_chk(sfc_pkg::OP_FCLR, 3'(i), 2'h0, e);
		end
	endtask : t_index
	task t_bit;
		apb(1'b1, sfc_pkg::OFF_GPR_BASE + 8'h04, 32'h0000_0040);
		apb(1'b1, sfc_pkg::OFF_GPR_BASE + 8'h08, 32'h0000_0000);
		op_chk(sfc_pkg::OP_TSTORE, 3'h6, 2'h1, 8'h40);
		op_chk(sfc_pkg::OP_TLOAD, 3'h0, 2'h2, 8'h40);
		apb(1'b0, sfc_pkg::OFF_GPR_BASE + 8'h08, 32'h0000_0000);
		chk("gpr2", 32'h0000_0001, rv);
		op_chk(sfc_pkg::OP_TSTORE, 3'h0, 2'h1, 8'h00);
	endtask : t_bit
	task t_ctrl;
		sfc_pkg::sfc_op_type c;
		for (int k = 0; k < 3; k++) begin
			c = (k == 0) ? sfc_pkg::OP_SLEEP :
				(k == 1) ? sfc_pkg::OP_WDOG : sfc_pkg::OP_BREAK;
			op_chk(c, 3'h0, 2'h0, 8'h00);
			chk("sleep", 32'(k == 0), 32'(slp));
			chk("wdt", 32'(k == 1), 32'(wdt));
			chk("break", 32'(k == 2), 32'(brk));
		end
	endtask : t_ctrl
	task t_dacc;
		int s0;
		s0 = stall_cyc;
		u_src.dacc(1'b0, 0, lat);
		chk("sram lat", 32'h0000_0001, 32'(lat));
		chk("sram stall", 32'h0000_0000, 32'(stall_cyc - s0));
		s0 = stall_cyc;
		u_src.dacc(1'b1, 0, lat);
		chk("nvm lat", 32'h0000_0002, 32'(lat));
		chk("nvm stall", 32'h0000_0001, 32'(stall_cyc - s0));
		chk("done ready", 32'h0000_0000, 32'(dready));
		s0 = stall_cyc;
		u_src.dacc(1'b1, 2, lat);
		chk("busy lat", 32'h0000_0003, 32'(lat));
		chk("busy stall", 32'h0000_0002, 32'(stall_cyc - s0));
	endtask : t_dacc
	task t_regs;
		logic [31:0] s;
		apb(1'b1, sfc_pkg::OFF_FLAGS, 32'h0000_000c);
		apb(1'b0, sfc_pkg::OFF_FLAGS, 32'h0000_0000);
		chk("flags rd", 32'h0000_000c, rv);
		apb(1'b0, sfc_pkg::OFF_STATUS, 32'h0000_0000);
		s = rv;
		chk("status rd", 32'h0000_1900, s);
		apb(1'b1, sfc_pkg::OFF_STATUS, 32'hffff_ffff);
		apb(1'b0, sfc_pkg::OFF_STATUS, 32'h0000_0000);
		chk("status", s, rv);
		apb(1'b1, sfc_pkg::OFF_CMD, 32'h0000_0005);
		apb(1'b0, sfc_pkg::OFF_FLAGS, 32'h0000_0000);
		chk("cmd effect", 32'h0000_002c, rv);
		apb(1'b0, sfc_pkg::OFF_CMD, 32'h0000_0000);
		chk("cmd rd", 32'h0000_0000, rv);
		apb(1'b0, 8'hf0, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, 32'(ev));
	endtask : t_regs
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		fail_count++;
		finish_test();
	end
	initial begin
		i_rstn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("rst flags", 32'h0000_0000, 32'(flags));
		chk("rst ready", 32'h0000_0001, 32'(dready));
		t_half();
		t_index();
		t_bit();
		t_ctrl();
		t_dacc();
		t_regs();
		finish_test();
	end
endmodule : status_flag_and_mcu_control_ops_tb
